//--- hdl/udf_cfg.svh
// Offsets, field positions and reset values of the unknown-destination
// forwarding control registers. Definitions only.
`ifndef UDF_CFG_SVH
`define UDF_CFG_SVH

`define UDF_ADDR_W       8
`define UDF_DATA_W       8

`define UDF_OFF_UC       8'h83
`define UDF_OFF_DRV_MC   8'h84
`define UDF_OFF_VID      8'h85
`define UDF_OFF_MISC     8'h86

`define UDF_EN_POS       5
`define UDF_MAP_MSB      4
`define UDF_MAP_LSB      0
`define UDF_DRV_MSB      7
`define UDF_DRV_LSB      6
`define UDF_MISC_MSB     6
`define UDF_MISC_LSB     0

`define UDF_CTRL_RST     6'h00
`define UDF_DRV_RST      2'h1
`define UDF_MISC_RST     7'h00
`define UDF_RD_IDLE      8'h00
`define UDF_FWD_DROP     5'h10

`endif

//--- hdl/udf_pkg.sv
// Types shared by the unknown-destination forwarding control block.
// Assumes udf_cfg.svh for the numeric constants.
package udf_pkg;

  // Class of a packet whose destination or VLAN lookup missed
  typedef enum logic [1:0]
  {
    UDF_CLS_UC  = 2'h0,
    UDF_CLS_MC  = 2'h1,
    UDF_CLS_VID = 2'h3
  } udf_class_e;

  // One class's forward enable and port map
  typedef struct packed
  {
    logic       en;
    logic [4:0] map;
  } udf_ctrl_s;

  // Forwarding decision handed back to the lookup engine
  typedef struct packed
  {
    logic       drop;
    logic [3:0] mask;
  } udf_fwd_s;

endpackage

//--- hdl/udf_field_reg.sv
// One software-writable register field with a constant reset value.
// Assumes the write enable comes from logic on the same clock.
`timescale 1ns/1ps
module udf_field_reg
#(
  parameter int             WIDTH = 6,
  parameter logic [WIDTH-1:0] RST = '0
)
(
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_we,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_q <= RST;
    end
    else if (i_we)
    begin
      o_q <= i_d;
    end
  end

endmodule

//--- hdl/udf_map_decode.sv
// Turns one class's enable and port map into a drop flag and port mask.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module udf_map_decode
(
  input  wire udf_pkg::udf_ctrl_s i_ctrl,
  output udf_pkg::udf_fwd_s       o_fwd
);

  function automatic udf_pkg::udf_fwd_s decode(udf_pkg::udf_ctrl_s c);
    udf_pkg::udf_fwd_s f;
    // Bit 0 is ignored; bits 4..1 select ports 4..1
    f.mask = c.en ? c.map[4:1] : 4'h0;
    // Disabled, 00000 and reserved 00001 all leave an empty mask: drop
    f.drop = (f.mask == 4'h0);
    return f;
  endfunction

  always_comb
  begin
    o_fwd = decode(i_ctrl);
  end

endmodule

//--- hdl/udf_ctrl.sv
// Unknown unicast, unknown multicast and unknown VID forwarding control
// registers, plus the chip output drive-strength select.
// Assumes the management port and the lookup engine share i_clk.
`timescale 1ns/1ps
`include "udf_cfg.svh"

module udf_ctrl
(
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  // Register access from the management port
  input  wire logic                     i_wr_en,
  input  wire logic                     i_rd_en,
  input  wire logic [`UDF_ADDR_W-1:0]   i_addr,
  input  wire logic [`UDF_DATA_W-1:0]   i_wr_data,
  output logic      [`UDF_DATA_W-1:0]   o_rd_data,
  output logic                          o_rd_valid,
  // Lookup miss from the forwarding engine
  input  wire logic                     i_lkp_valid,
  input  wire udf_pkg::udf_class_e      i_lkp_class,
  output logic                          o_fwd_valid,
  output udf_pkg::udf_fwd_s             o_fwd,
  // Pad control and raw filter settings
  output logic      [1:0]               o_drive_strength,
  output logic      [6:0]               o_misc_ctrl
);

  // Field widths follow from the bit positions
  localparam int CTRL_W = `UDF_EN_POS - `UDF_MAP_LSB + 1;
  localparam int DRV_W  = `UDF_DRV_MSB - `UDF_DRV_LSB + 1;
  localparam int MISC_W = `UDF_MISC_MSB - `UDF_MISC_LSB + 1;

  udf_pkg::udf_ctrl_s uc_ctrl;
  udf_pkg::udf_ctrl_s mc_ctrl;
  udf_pkg::udf_ctrl_s vid_ctrl;
  udf_pkg::udf_fwd_s  uc_fwd;
  udf_pkg::udf_fwd_s  mc_fwd;
  udf_pkg::udf_fwd_s  vid_fwd;
  udf_pkg::udf_fwd_s  sel_fwd;
  logic [5:0]         wr_ctrl;
  logic [1:0]         wr_drv;
  logic [6:0]         wr_misc;
  logic               we_uc;
  logic               we_mc;
  logic               we_vid;
  logic               we_misc;
  logic [`UDF_DATA_W-1:0] rd_nxt;
  logic [3:0]         wr_sel;
  logic [3:0]         rd_sel;

  // One-hot register select: bit 0 unicast up to bit 3 misc
  function automatic logic [3:0] addr_sel
  (
    input logic [`UDF_ADDR_W-1:0] addr
  );
    logic [3:0] sel;
    sel    = 4'h0;
    sel[0] = (addr == `UDF_OFF_UC);
    sel[1] = (addr == `UDF_OFF_DRV_MC);
    sel[2] = (addr == `UDF_OFF_VID);
    sel[3] = (addr == `UDF_OFF_MISC);
    return sel;
  endfunction

  // Readback word of the selected register; reserved bits read zero
  function automatic logic [`UDF_DATA_W-1:0] rd_word
  (
    input logic [3:0]         sel,
    input udf_pkg::udf_ctrl_s uc,
    input udf_pkg::udf_ctrl_s mc,
    input udf_pkg::udf_ctrl_s vid,
    input logic [1:0]         drv,
    input logic [6:0]         misc
  );
    logic [`UDF_DATA_W-1:0] w;
    w = `UDF_RD_IDLE;
    case (sel)
      4'h1:    w = {2'h0, uc};
      4'h2:    w = {drv, mc};
      4'h4:    w = {2'h0, vid};
      4'h8:    w = {1'b0, misc};
      default: w = `UDF_RD_IDLE;
    endcase
    return w;
  endfunction

  // Decision for one miss class; unencoded classes are filtered
  function automatic udf_pkg::udf_fwd_s pick_fwd
  (
    input udf_pkg::udf_class_e cls,
    input udf_pkg::udf_fwd_s   uc,
    input udf_pkg::udf_fwd_s   mc,
    input udf_pkg::udf_fwd_s   vid
  );
    udf_pkg::udf_fwd_s f;
    f = `UDF_FWD_DROP;
    case (cls)
      udf_pkg::UDF_CLS_UC:  f = uc;
      udf_pkg::UDF_CLS_MC:  f = mc;
      udf_pkg::UDF_CLS_VID: f = vid;
      default:              f = `UDF_FWD_DROP;
    endcase
    return f;
  endfunction

  // Field extraction; reserved bits are dropped here
  always_comb
  begin
    wr_ctrl = i_wr_data[`UDF_EN_POS:`UDF_MAP_LSB];
    wr_drv  = i_wr_data[`UDF_DRV_MSB:`UDF_DRV_LSB];
    wr_misc = i_wr_data[`UDF_MISC_MSB:`UDF_MISC_LSB];
  end

  always_comb
  begin
    wr_sel = addr_sel(i_addr) & {4{i_wr_en}};
  end

  // Per-register write enables
  always_comb
  begin
    we_uc   = wr_sel[0];
    we_mc   = wr_sel[1];
    we_vid  = wr_sel[2];
    we_misc = wr_sel[3];
  end

  udf_field_reg #(.WIDTH(CTRL_W), .RST(`UDF_CTRL_RST)) u_uc_reg
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (we_uc),
    .i_d     (wr_ctrl),
    .o_q     (uc_ctrl)
  );

  udf_field_reg #(.WIDTH(CTRL_W), .RST(`UDF_CTRL_RST)) u_mc_reg
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (we_mc),
    .i_d     (wr_ctrl),
    .o_q     (mc_ctrl)
  );

  // drive strength held, driven to pads
  udf_field_reg #(.WIDTH(DRV_W), .RST(`UDF_DRV_RST)) u_drv_reg
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (we_mc),
    .i_d     (wr_drv),
    .o_q     (o_drive_strength)
  );

  udf_field_reg #(.WIDTH(CTRL_W), .RST(`UDF_CTRL_RST)) u_vid_reg
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (we_vid),
    .i_d     (wr_ctrl),
    .o_q     (vid_ctrl)
  );

  udf_field_reg #(.WIDTH(MISC_W), .RST(`UDF_MISC_RST)) u_misc_reg
  (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_we    (we_misc),
    .i_d     (wr_misc),
    .o_q     (o_misc_ctrl)
  );

  udf_map_decode u_uc_dec
  (
    .i_ctrl (uc_ctrl),
    .o_fwd  (uc_fwd)
  );

  udf_map_decode u_mc_dec
  (
    .i_ctrl (mc_ctrl),
    .o_fwd  (mc_fwd)
  );

  udf_map_decode u_vid_dec
  (
    .i_ctrl (vid_ctrl),
    .o_fwd  (vid_fwd)
  );

  // per-port mask chosen by miss class
  always_comb
  begin
    sel_fwd = pick_fwd(i_lkp_class, uc_fwd, mc_fwd, vid_fwd);
  end

  // Decision valid pulses one cycle after each miss
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fwd_valid <= 1'b0;
    end
    else
    begin
      o_fwd_valid <= i_lkp_valid;
    end
  end

  // decision word held until the next miss
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_fwd <= `UDF_FWD_DROP;
    end
    else if (i_lkp_valid)
    begin
      o_fwd <= sel_fwd;
    end
  end

  always_comb
  begin
    rd_sel = addr_sel(i_addr);
  end

  // readback with reserved bits as zero
  always_comb
  begin
    rd_nxt = rd_word(rd_sel, uc_ctrl, mc_ctrl, vid_ctrl,
                     o_drive_strength, o_misc_ctrl);
  end

  // Read answer pulses one cycle after each read
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
    end
  end

  // Read data held until the next read
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rd_data <= `UDF_RD_IDLE;
    end
    else if (i_rd_en)
    begin
      o_rd_data <= rd_nxt;
    end
  end

endmodule

//--- dv/udf_ctrl_sva.sv
// Port checks of the unknown-destination forwarding control block.
// Assumes it is bound onto udf_ctrl; one clock domain.
`timescale 1ns/1ps
`include "udf_cfg.svh"
module udf_ctrl_sva
(
  input wire logic              i_clk,
  input wire logic              i_rst_n,
  input wire logic              i_wr_en,
  input wire logic              i_rd_en,
  input wire logic [7:0]        i_addr,
  input wire logic [7:0]        i_wr_data,
  input wire logic [7:0]        o_rd_data,
  input wire logic              o_rd_valid,
  input wire logic              i_lkp_valid,
  input wire udf_pkg::udf_class_e i_lkp_class,
  input wire logic              o_fwd_valid,
  input wire udf_pkg::udf_fwd_s o_fwd,
  input wire logic [1:0]        o_drive_strength,
  input wire logic [6:0]        o_misc_ctrl
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] wd_r;
  always_ff @(posedge i_clk)
    wd_r <= i_wr_data;
  // Shadow of the unicast control and the mask it asks for
  logic [5:0] uc_sh_r;
  logic [3:0] uc_exp_r;
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      uc_sh_r  <= 6'h00;
      uc_exp_r <= 4'h0;
    end
    else
    begin
      uc_exp_r <= uc_sh_r[5] ? uc_sh_r[4:1] : 4'h0;
      if (i_wr_en && i_addr == `UDF_OFF_UC)
        uc_sh_r <= i_wr_data[5:0];
    end
  sequence s_drv_wr;
    i_wr_en && i_addr == `UDF_OFF_DRV_MC;
  endsequence
  sequence s_misc_wr;
    i_wr_en && i_addr == `UDF_OFF_MISC;
  endsequence
  a_rd_answer: assert property (o_rd_valid == $past(i_rd_en))
    else $error("read answer timing wrong");
  a_rd_hold: assert property (!i_rd_en |=> $stable(o_rd_data))
    else $error("read data changed without read");
  a_unmapped_zero: assert property (i_rd_en &&
    (i_addr < 8'h83 || i_addr > 8'h86) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_fwd_answer: assert property (i_lkp_valid |=> o_fwd_valid)
    else $error("lookup answer missing");
  a_fwd_idle: assert property (!i_lkp_valid |=>
    !o_fwd_valid && $stable(o_fwd))
    else $error("decision without request");
  a_drop_empty: assert property (o_fwd_valid |->
    o_fwd.drop == (o_fwd.mask == 4'h0))
    else $error("drop flag disagrees with mask");
  a_drv_write: assert property (s_drv_wr |=>
    o_drive_strength == wd_r[7:6])
    else $error("drive code not written");
  a_drv_hold: assert property (!(i_wr_en &&
    i_addr == `UDF_OFF_DRV_MC) |=> $stable(o_drive_strength))
    else $error("drive code changed unwritten");
  a_misc_write: assert property (s_misc_wr |=>
    o_misc_ctrl == wd_r[6:0])
    else $error("misc field not written");
  a_uc_decision: assert property (i_lkp_valid &&
    i_lkp_class == udf_pkg::UDF_CLS_UC |=> o_fwd.mask == uc_exp_r &&
    o_fwd.drop == (uc_exp_r == 4'h0))
    else $error("unicast decision wrong");
endmodule
bind udf_ctrl udf_ctrl_sva u_sva (.*);

//--- dv/tb_udf_ctrl.sv
// Self-checking bench for udf_ctrl registers and lookups.
// Assumes udf_pkg, the design and the checker are compiled first.
`timescale 1ns/1ps
module tb_udf_ctrl;
  logic                i_clk = 0;
  logic                i_rst_n = 0;
  logic                wr = 0;
  logic                rd = 0;
  logic                lv = 0;
  udf_pkg::udf_class_e cls = udf_pkg::UDF_CLS_UC;
  logic [7:0]          a = 0;
  logic [7:0]          d = 0;
  logic [7:0]          rdata;
  logic                rvalid;
  logic                fvalid;
  udf_pkg::udf_fwd_s   fwd;
  logic [1:0]          drv;
  logic [6:0]          misc;
  logic [7:0]          v;
  logic [3:0]          f;
  int                  n_mismatch = 0;
  int                  checks = 0;
  int                  cyc = 0;
  udf_ctrl u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(a), .i_wr_data(d), .o_rd_data(rdata),
    .o_rd_valid(rvalid), .i_lkp_valid(lv), .i_lkp_class(cls),
    .o_fwd_valid(fvalid), .o_fwd(fwd), .o_drive_strength(drv),
    .o_misc_ctrl(misc));
  always #2 i_clk = ~i_clk;
  task automatic print_verdict;
    $display("Mismatches %0d, checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      print_verdict;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [7:0] ad, input logic [7:0] dd);
    @(posedge i_clk) #1;
    wr = 1;
    a = ad;
    d = dd;
    @(posedge i_clk) #1;
    wr = 0;
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge i_clk) #1;
    rd = 1;
    a = ad;
    @(posedge i_clk) #1;
    rd = 0;
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic lk(input logic [1:0] c, input logic [4:0] exp);
    @(posedge i_clk) #1;
    lv = 1;
    cls = udf_pkg::udf_class_e'(c);
    @(posedge i_clk) #1;
    lv = 0;
    chk({fvalid, 2'h0, fwd}, {3'h4, exp});
  endtask
  initial
  begin
    repeat (4) @(posedge i_clk);
    #1;
    i_rst_n = 1;
    rdc(8'h83, 8'h00);
    rdc(8'h84, 8'h40);
    rdc(8'h85, 8'h00);
    rdc(8'h86, 8'h00);
    lk(2'h0, 5'h10);
    for (int r = 0; r < 3; r++)
      for (int k = 0; k < 64; k++)
      begin
        v = {k[1:0], k[5:0]};
        f = v[4:1];
        wrr(8'h83 + r[7:0], v);
        rdc(8'h83 + r[7:0], r == 1 ? v : {2'h0, v[5:0]});
        lk(r == 2 ? 2'h3 : r[1:0],
          v[5] && f != 0 ? {1'b0, f} : 5'h10);
        if (r == 1)
          chk({6'h00, drv}, {6'h00, v[7:6]});
      end
    lk(2'h2, 5'h10);
    wrr(8'h86, 8'hFF);
    rdc(8'h86, 8'h7F);
    chk({1'b0, misc}, 8'h7F);
    wrr(8'h87, 8'hFF);
    rdc(8'h87, 8'h00);
    rdc(8'h84, 8'hFF);
    rdc(8'h85, 8'h3F);
    i_rst_n = 0;
    repeat (4) @(posedge i_clk);
    #1;
    i_rst_n = 1;
    rdc(8'h83, 8'h00);
    rdc(8'h84, 8'h40);
    rdc(8'h85, 8'h00);
    rdc(8'h86, 8'h00);
    lk(2'h1, 5'h10);
    chk({6'h00, drv}, 8'h01);
    print_verdict;
  end
endmodule
